// *** pgu_paging_unit.sv ***
// Paging unit: translation buffer, directory cache, table walker, register slave.
// Assumes memory answers reads/writes with a one-cycle mem_ack_in and the core
// holds a lookup request until the edge that takes it.
module pgu_paging_unit
  import pgu_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  // Avalon-MM register slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Core lookup port
  input wire logic req_valid_in,
  input wire pgu_req_t req_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output pgu_rsp_t rsp_out,
  output logic page_size_ext_out,
  // Table memory port
  output logic mem_req_out,
  output logic mem_write_out,
  output logic [31:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_rdata_in
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [31:0] directory_base_control_reg;
  logic [31:0] config_control_reg_four;
  logic avs_done;
  logic flush_all;
  logic inval_one;
  logic [31:0] inval_addr;
  logic [31:0] fault_count;
  logic [31:0] last_fault_addr;

  logic [TLB_WAYS-1:0] tlb_valid [TLB_SETS];
  logic [16:0] tlb_tag [TLB_SETS][TLB_WAYS];
  logic [19:0] tlb_frame [TLB_SETS][TLB_WAYS];
  logic [TLB_WAYS-1:0] tlb_write_ok [TLB_SETS];
  logic [TLB_WAYS-1:0] tlb_user_ok [TLB_SETS];
  logic [TLB_WAYS-1:0] tlb_dirty [TLB_SETS];
  logic [2:0] tlb_plru [TLB_SETS];

  logic [DIRC_ENTRIES-1:0] dirc_valid;
  logic [9:0] dirc_index [DIRC_ENTRIES];
  logic [31:0] dirc_entry [DIRC_ENTRIES];
  logic dirc_mru;

  pgu_state_t state;
  pgu_req_t cur;
  logic [31:0] directory_entry;
  logic [31:0] page_table_entry;

  // ------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------
  wire avs_access = avs_read_in | avs_write_in;
  wire dir_cache_enable = config_control_reg_four[CFG_DIR_CACHE_EN_BIT];
  // One wait cycle then the access completes
  assign avs_waitrequest_out = avs_access & ~avs_done;

  // Handshake phase: done pulses on the completing edge
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      avs_done <= 1'b0;
    end else begin
      avs_done <= avs_access & ~avs_done;
    end
  end

  wire avs_wr_fire = avs_write_in & avs_done;
  wire avs_rd_fire = avs_read_in & avs_done;

  // Control register writes
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      directory_base_control_reg <= DIR_BASE_RESET;
      config_control_reg_four <= CFG_RESET;
    end else if (avs_wr_fire) begin
      if (avs_address_in == ADDR_DIR_BASE) begin
        directory_base_control_reg <= {avs_writedata_in[31:12], 12'h000};
      end
      if (avs_address_in == ADDR_CONFIG) begin
        config_control_reg_four <= {27'h0000000, avs_writedata_in[CFG_DIR_CACHE_EN_BIT], 4'h0};
      end
    end
  end

  // Flush pulses and the invalidate-page address
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      flush_all <= 1'b0;
      inval_one <= 1'b0;
      inval_addr <= 32'h0000_0000;
    end else begin
      flush_all <= avs_wr_fire && avs_address_in == ADDR_DIR_BASE;
      inval_one <= avs_wr_fire && avs_address_in == ADDR_INVAL;
      if (avs_wr_fire && avs_address_in == ADDR_INVAL) begin
        inval_addr <= avs_writedata_in;
      end
    end
  end

  // Read data mux
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in & ~avs_done) begin
      unique case (avs_address_in)
        ADDR_DIR_BASE: avs_readdata_out <= directory_base_control_reg;
        ADDR_CONFIG: avs_readdata_out <= config_control_reg_four;
        ADDR_INVAL: avs_readdata_out <= last_fault_addr;
        ADDR_STATUS: avs_readdata_out <= fault_count;
        default: avs_readdata_out <= UNMAPPED_READ;
      endcase
    end
  end

  assign page_size_ext_out = PAGE_SIZE_EXT_CAP;

  // ------------------------------------------------------------
  // Buffer lookup
  // ------------------------------------------------------------
  wire [2:0] req_set = req_in.lin_addr[14:12];
  wire [16:0] req_tag = req_in.lin_addr[31:15];
  logic [TLB_WAYS-1:0] hit_vec;
  logic [1:0] hit_way;
  logic [1:0] victim_way;

  // Tag compare across the four ways of the indexed set
  always_comb begin
    hit_vec = '0;
    hit_way = 2'd0;
    for (int w = 0; w < TLB_WAYS; w++) begin
      hit_vec[w] = tlb_valid[req_set][w] && tlb_tag[req_set][w] == req_tag;
      if (hit_vec[w]) begin
        hit_way = w[1:0];
      end
    end
  end

  // Tree pseudo-LRU victim for the walked set
  wire [2:0] cur_set = cur.lin_addr[14:12];
  always_comb begin
    victim_way = tlb_plru[cur_set][0] ? {1'b1, tlb_plru[cur_set][2]}
                                      : {1'b0, tlb_plru[cur_set][1]};
  end

  // A rewalk of a cached page reuses its way, so no duplicate tag survives
  logic [1:0] fill_way;
  always_comb begin
    fill_way = victim_way;
    for (int w = 0; w < TLB_WAYS; w++) begin
      if (tlb_valid[cur_set][w] && tlb_tag[cur_set][w] == cur.lin_addr[31:15]) begin
        fill_way = w[1:0];
      end
    end
  end

  // A hit is usable unless a write needs the dirty flag set first
  wire hit_dirty_ok = ~req_in.write | tlb_dirty[req_set][hit_way];
  wire tlb_hit = |hit_vec & hit_dirty_ok;
  wire hit_prot_bad = (req_in.write & ~tlb_write_ok[req_set][hit_way])
                    | (req_in.user & ~tlb_user_ok[req_set][hit_way]);
  wire take = req_valid_in && state == ST_IDLE && !flush_all && !inval_one;
  assign req_ready_out = state == ST_IDLE && !flush_all && !inval_one;

  // ------------------------------------------------------------
  // Directory cache lookup
  // ------------------------------------------------------------
  wire [9:0] directory_index = cur.lin_addr[31:22];
  wire [9:0] table_index = cur.lin_addr[21:12];
  wire [11:0] page_offset = cur.lin_addr[11:0];
  logic dirc_hit;
  logic [31:0] dirc_hit_entry;

  always_comb begin
    dirc_hit = 1'b0;
    dirc_hit_entry = 32'h0000_0000;
    for (int i = 0; i < DIRC_ENTRIES; i++) begin
      if (dir_cache_enable && dirc_valid[i] && dirc_index[i] == directory_index) begin
        dirc_hit = 1'b1;
        dirc_hit_entry = dirc_entry[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Walk state machine
  // ------------------------------------------------------------
  wire pte_prot_bad = (cur.write & ~mem_rdata_in[ENT_WRITABLE])
                    | (cur.user & ~mem_rdata_in[ENT_USER])
                    | (cur.write & ~directory_entry[ENT_WRITABLE])
                    | (cur.user & ~directory_entry[ENT_USER]);
  logic walk_fault;
  logic walk_np;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      cur <= '0;
      directory_entry <= 32'h0000_0000;
      page_table_entry <= 32'h0000_0000;
      walk_fault <= 1'b0;
      walk_np <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (take) begin
            cur <= req_in;
            walk_fault <= 1'b0;
            walk_np <= 1'b0;
            if (!tlb_hit) begin
              state <= ST_DIR_RD;
            end
          end
        end
        ST_DIR_RD: begin
          if (dirc_hit) begin
            directory_entry <= dirc_hit_entry;
            state <= ST_PT_RD;
          end else if (mem_ack_in) begin
            directory_entry <= mem_rdata_in;
            if (!mem_rdata_in[ENT_PRESENT]) begin
              walk_fault <= 1'b1;
              walk_np <= 1'b1;
              state <= ST_DONE;
            end else if (!mem_rdata_in[ENT_ACCESSED]) begin
              state <= ST_DIR_WR;
            end else begin
              state <= ST_PT_RD;
            end
          end
        end
        ST_DIR_WR: begin
          if (mem_ack_in) begin
            directory_entry[ENT_ACCESSED] <= 1'b1;
            state <= ST_PT_RD;
          end
        end
        ST_PT_RD: begin
          if (mem_ack_in) begin
            page_table_entry <= mem_rdata_in;
            if (!mem_rdata_in[ENT_PRESENT]) begin
              walk_fault <= 1'b1;
              walk_np <= 1'b1;
              state <= ST_DONE;
            end else if (pte_prot_bad) begin
              walk_fault <= 1'b1;
              state <= ST_DONE;
            end else if (!mem_rdata_in[ENT_ACCESSED]
                         || (cur.write && !mem_rdata_in[ENT_DIRTY])) begin
              state <= ST_PT_WR;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_PT_WR: begin
          if (mem_ack_in) begin
            page_table_entry[ENT_ACCESSED] <= 1'b1;
            page_table_entry[ENT_DIRTY] <= page_table_entry[ENT_DIRTY] | cur.write;
            state <= ST_DONE;
          end
        end
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Memory request drive
  always_comb begin
    mem_req_out = 1'b0;
    mem_write_out = 1'b0;
    mem_addr_out = 32'h0000_0000;
    mem_wdata_out = 32'h0000_0000;
    unique case (state)
      ST_DIR_RD: begin
        mem_req_out = ~dirc_hit;
        mem_addr_out = {directory_base_control_reg[31:12], directory_index, 2'b00};
      end
      ST_DIR_WR: begin
        mem_req_out = 1'b1;
        mem_write_out = 1'b1;
        mem_addr_out = {directory_base_control_reg[31:12], directory_index, 2'b00};
        mem_wdata_out = directory_entry | (32'h1 << ENT_ACCESSED);
      end
      ST_PT_RD: begin
        mem_req_out = 1'b1;
        mem_addr_out = {directory_entry[31:12], table_index, 2'b00};
      end
      ST_PT_WR: begin
        mem_req_out = 1'b1;
        mem_write_out = 1'b1;
        mem_addr_out = {directory_entry[31:12], table_index, 2'b00};
        mem_wdata_out = page_table_entry | (32'h1 << ENT_ACCESSED)
                      | ({31'h0, cur.write} << ENT_DIRTY);
      end
      default: begin
        mem_req_out = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Answer to the core
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rsp_valid_out <= 1'b0;
      rsp_out <= '0;
    end else begin
      rsp_valid_out <= 1'b0;
      if (take && tlb_hit) begin
        rsp_valid_out <= 1'b1;
        rsp_out.phys_addr <= {tlb_frame[req_set][hit_way], req_in.lin_addr[11:0]};
        rsp_out.fault <= hit_prot_bad;
        rsp_out.fault_not_present <= 1'b0;
        rsp_out.fault_protect <= hit_prot_bad;
      end else if (state == ST_DONE) begin
        rsp_valid_out <= 1'b1;
        rsp_out.phys_addr <= walk_fault ? cur.lin_addr
                                        : {page_table_entry[31:12], page_offset};
        rsp_out.fault <= walk_fault;
        rsp_out.fault_not_present <= walk_np;
        rsp_out.fault_protect <= walk_fault & ~walk_np;
      end
    end
  end

  // Fault statistics visible to software
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      fault_count <= 32'h0000_0000;
      last_fault_addr <= 32'h0000_0000;
    end else if (state == ST_DONE && walk_fault) begin
      fault_count <= fault_count + 32'h1;
      last_fault_addr <= cur.lin_addr;
    end
  end

  // ------------------------------------------------------------
  // Buffer fill, replacement and invalidation
  // ------------------------------------------------------------
  wire fill = state == ST_DONE && !walk_fault;
  wire [2:0] inv_set = inval_addr[14:12];

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int s = 0; s < TLB_SETS; s++) begin
        tlb_valid[s] <= '0;
        tlb_plru[s] <= 3'b000;
      end
    end else if (flush_all) begin
      for (int s = 0; s < TLB_SETS; s++) begin
        tlb_valid[s] <= '0;
      end
    end else begin
      if (inval_one) begin
        for (int w = 0; w < TLB_WAYS; w++) begin
          if (tlb_tag[inv_set][w] == inval_addr[31:15]) begin
            tlb_valid[inv_set][w] <= 1'b0;
          end
        end
      end
      if (take && tlb_hit) begin
        tlb_plru[req_set][0] <= ~hit_way[1];
        tlb_plru[req_set][hit_way[1] ? 2 : 1] <= ~hit_way[0];
      end
      if (fill) begin
        tlb_valid[cur_set][fill_way] <= 1'b1;
        tlb_plru[cur_set][0] <= ~fill_way[1];
        tlb_plru[cur_set][fill_way[1] ? 2 : 1] <= ~fill_way[0];
      end
    end
  end

  // Fill payload; a stale entry of the same tag is overwritten in place
  always_ff @(posedge clk_in) begin
    if (fill) begin
      tlb_tag[cur_set][fill_way] <= cur.lin_addr[31:15];
      tlb_frame[cur_set][fill_way] <= page_table_entry[31:12];
      tlb_write_ok[cur_set][fill_way] <= page_table_entry[ENT_WRITABLE]
                                       & directory_entry[ENT_WRITABLE];
      tlb_user_ok[cur_set][fill_way] <= page_table_entry[ENT_USER]
                                      & directory_entry[ENT_USER];
      tlb_dirty[cur_set][fill_way] <= page_table_entry[ENT_DIRTY];
    end
  end

  // ------------------------------------------------------------
  // Directory entry cache
  // ------------------------------------------------------------
  logic dirc_hit_now;
  wire dirc_fill = state == ST_PT_RD && mem_ack_in && !dirc_hit_now;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      dirc_hit_now <= 1'b0;
    end else if (state == ST_DIR_RD) begin
      dirc_hit_now <= dirc_hit;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      dirc_valid <= '0;
      dirc_mru <= 1'b0;
    end else if (flush_all || !dir_cache_enable) begin
      dirc_valid <= '0;
    end else if (dirc_fill) begin
      dirc_valid[~dirc_mru] <= 1'b1;
      dirc_index[~dirc_mru] <= directory_index;
      dirc_entry[~dirc_mru] <= directory_entry;
      dirc_mru <= ~dirc_mru;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_dir_index_addr: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == ST_DIR_RD && mem_req_out |->
      mem_addr_out == {directory_base_control_reg[31:12], cur.lin_addr[31:22], 2'b00})
    else $error("directory entry address wrong");
  a_table_index_addr: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == ST_PT_RD |-> mem_addr_out[11:0] == {cur.lin_addr[21:12], 2'b00})
    else $error("page entry address wrong");
  a_offset_pass: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == ST_DONE && !walk_fault |=>
      rsp_valid_out
      && rsp_out.phys_addr == {$past(page_table_entry[31:12]), $past(cur.lin_addr[11:0])})
    else $error("physical address not frame plus offset");
  a_np_dir_fault: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == ST_DIR_RD && !dirc_hit && mem_ack_in && !mem_rdata_in[ENT_PRESENT] |=>
      state == ST_DONE ##1 rsp_valid_out && rsp_out.fault_not_present)
    else $error("absent directory entry not faulted");
  a_dirty_before: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == ST_DONE && !walk_fault && cur.write |-> page_table_entry[ENT_DIRTY])
    else $error("dirty flag not written");
  a_flush_clears: assert property (@(posedge clk_in) disable iff (!resetn_in)
    flush_all |=> tlb_valid[0] == '0 && tlb_valid[7] == '0 && dirc_valid == '0)
    else $error("flush left valid entries");
  a_dirc_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !dir_cache_enable |-> !dirc_hit)
    else $error("directory cache hit while disabled");
  a_hit_no_walk: assert property (@(posedge clk_in) disable iff (!resetn_in)
    take && tlb_hit |=> state == ST_IDLE && rsp_valid_out && !mem_req_out)
    else $error("hit started a walk");
  c_tlb_hit: cover property (@(posedge clk_in) take && tlb_hit);
  c_dirc_hit: cover property (@(posedge clk_in) state == ST_DIR_RD && dirc_hit);
  c_walk_fault: cover property (@(posedge clk_in) state == ST_DONE && walk_fault);

endmodule // pgu_paging_unit

// *** pgu_pkg.sv ***
// Constants and carrier types for the paging unit with translation buffer.
// Assumes a single 100 MHz core clock and a word-wide memory port for table entries.
//
// Function
// - Linear bits 31:22 index one 32-bit directory entry.
// - Linear bits 21:12 index one 32-bit entry in the page table.
// - Linear bits 11:0 pass unchanged as offset in a 4 KB frame.
// - Physical address is frame base from page entry plus page offset.
// - Directory base comes from base register, treated 4 KB aligned.
// - Only 4 KB pages; page size extension capability reads zero.
// - Page table entry read only when directory entry present flag set.
// - With page entry present, update accessed and dirty before answering; on a protection fault the walk answers with neither updated.
// - Set accessed flag in directory and page entries when clear.
// - Set page dirty flag before the first write to the page.
// - Fault when a touched directory or page entry is not present.
// - Ignore all other entry bits while present flag is clear.
// - Fault when the reference breaks the entries' protection attributes.
// - Thirty-two entry four-way set-associative buffer filled on walks.
// - Buffer hit yields physical address without any table walk; a write hitting an entry with dirty clear walks both tables.
// - Loading the directory base register invalidates every buffer entry.
// - Invalidate-page request invalidates the one entry for that address.
// - Two most recent directory entries cached; hit needs one table read.
// - Directory cache off after reset; on only while enable bit 4 set.
// - Entry bits 31:12 base, bit 6 dirty, bit 5 accessed.
// - Entry bit 2 user-accessible, bit 1 writable.
// - Entry bit 0 present flag.
package pgu_pkg;

  // ------------------------------------------------------------
  // Register map (Avalon word byte addresses)
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_DIR_BASE = 4'h0;
  localparam logic [3:0] ADDR_CONFIG = 4'h4;
  localparam logic [3:0] ADDR_INVAL = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam int CFG_DIR_CACHE_EN_BIT = 4;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] DIR_BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  localparam logic PAGE_SIZE_EXT_CAP = 1'b0;

  // ------------------------------------------------------------
  // Entry fields
  // ------------------------------------------------------------
  localparam int ENT_PRESENT = 0;
  localparam int ENT_WRITABLE = 1;
  localparam int ENT_USER = 2;
  localparam int ENT_ACCESSED = 5;
  localparam int ENT_DIRTY = 6;

  // ------------------------------------------------------------
  // Buffer geometry
  // ------------------------------------------------------------
  localparam int TLB_WAYS = 4;
  localparam int TLB_SETS = 8;
  localparam int DIRC_ENTRIES = 2;

  // Lookup request from the core pipeline
  typedef struct packed {
    logic [31:0] lin_addr;
    logic write;
    logic user;
  } pgu_req_t;

  // Translation answer to the core pipeline
  typedef struct packed {
    logic [31:0] phys_addr;
    logic fault;
    logic fault_not_present;
    logic fault_protect;
  } pgu_rsp_t;

  // Walk states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DIR_RD = 3'b001,
    ST_DIR_WR = 3'b010,
    ST_PT_RD = 3'b011,
    ST_PT_WR = 3'b100,
    ST_DONE = 3'b101
  } pgu_state_t;

endpackage

// *** pgu_mem_model.sv ***
// Table memory beside the paging unit: word store, random latency, one-cycle ack.
// Assumes one outstanding access held until its ack.
module pgu_mem_model (
  input wire logic clk_in,
  input wire logic mem_req_in,
  input wire logic mem_write_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic [31:0] mem_wdata_in,
  output logic mem_ack_out,
  output logic [31:0] mem_rdata_out,
  output int reads_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] ram [logic [29:0]];
  int seed = 32'hCF933287;
  int gap = 0;
  initial begin
    mem_ack_out = 1'b0;
    mem_rdata_out = 32'h0;
    reads_out = 0;
  end
  // Answer after 0..2 idle cycles; data turns over when released
  always @(posedge clk_in) begin
    if (mem_ack_out) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
    end else if (mem_req_in && gap == 0) begin
      mem_ack_out <= 1'b1;
      gap <= {$random(seed)} % 3;
      if (mem_write_in) ram[mem_addr_in[31:2]] = mem_wdata_in;
      else begin
        mem_rdata_out <= ram[mem_addr_in[31:2]];
        reads_out <= reads_out + 1;
      end
    end else if (mem_req_in) gap <= gap - 1;
  end
endmodule // pgu_mem_model

// *** tb.sv ***
// Testbench for the paging unit: bus tasks, walk reference model, read counts.
// Assumes the memory model holds the tables and answers every table access.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pgu_pkg::*;
  logic clk_in = 0, resetn_in = 0, avs_read_in = 0, avs_write_in = 0, req_valid_in = 0;
  logic [3:0] avs_address_in = 4'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, mem_addr_out, mem_wdata_out;
  logic [31:0] mem_rdata_in, q, base;
  logic avs_waitrequest_out, req_ready_out, rsp_valid_out, pse, mem_req_out, mem_write_out;
  logic mem_ack_in;
  pgu_req_t req_in = '0;
  pgu_rsp_t rsp_out;
  int miscompares = 0, checked = 0, reads, nfault = 0, seed = 32'hCF933287;
  always #5 clk_in = ~clk_in;
  pgu_paging_unit uut (.clk_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .req_valid_in, .req_in,
    .req_ready_out, .rsp_valid_out, .rsp_out, .page_size_ext_out(pse), .mem_req_out,
    .mem_write_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_rdata_in);
  pgu_mem_model mem (.clk_in, .mem_req_in(mem_req_out), .mem_write_in(mem_write_out),
    .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .mem_ack_out(mem_ack_in),
    .mem_rdata_out(mem_rdata_in), .reads_out(reads));
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // Avalon access held until waitrequest is sampled low at a rising edge
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] v);
    int n;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= d;
    n = 0;
    do begin @(posedge clk_in); n++; end while (avs_waitrequest_out !== 1'b0 && n < 50);
    v = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n >= 50) chk(1'b0, "bus timeout");
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] v;
    avs(1'b0, a, 32'h0, v);
    chk(v === e, "register read");
  endtask
  // Reference walk, then one lookup compared with it
  task automatic look(input logic [31:0] lin, input logic wr, input logic usr, input int exp_rd);
    logic [29:0] da, pa;
    logic [31:0] de, pe;
    logic np, pf;
    int r0, n;
    r0 = reads;
    da = {base[31:12], lin[31:22]};
    de = mem.ram[da];
    pa = {de[31:12], lin[21:12]};
    pe = de[0] ? mem.ram[pa] : 32'h0;
    np = !(de[0] && pe[0]);
    pf = !np && ((wr && !(de[1] && pe[1])) || (usr && !(de[2] && pe[2])));
    nfault += int'(np || pf);
    @(posedge clk_in);
    req_in <= '{lin, wr, usr};
    req_valid_in <= 1'b1;
    // Valid drops at the edge that takes it, so no second lookup starts
    n = 0;
    do begin @(negedge clk_in); n++; end while (req_ready_out !== 1'b1 && n < 300);
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    do begin @(negedge clk_in); n++; end while (rsp_valid_out !== 1'b1 && n < 300);
    chk(rsp_valid_out === 1'b1, "no answer");
    chk(rsp_out[2:0] === {np | pf, np, pf}, "fault flags");
    if (!(np || pf)) chk(rsp_out.phys_addr === {pe[31:12], lin[11:0]}, "phys");
    chk(reads - r0 === exp_rd, "table reads");
    if (!(np || pf))
      chk(mem.ram[da][5] && mem.ram[pa][5] && (!wr || mem.ram[pa][6]), "flag");
    $display("test done: lookup %h", lin);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    test_done();
  end
  // Main sequence
  initial begin
    mem.ram[30'h400] = 32'h0000_2007;
    mem.ram[30'h401] = 32'hDEAD_BEE0;
    mem.ram[30'h803] = 32'h0005_0007;
    mem.ram[30'h804] = 32'h0006_0005;
    mem.ram[30'h805] = 32'h0007_0003;
    mem.ram[30'h806] = 32'hFFFF_FFFE;
    for (int k = 7; k < 34; k++) mem.ram[30'(2048 + k)] = {12'h0, k[7:0], 12'h007};
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(ADDR_CONFIG, CFG_RESET);
    rd(ADDR_DIR_BASE, DIR_BASE_RESET);
    rd(4'h2, UNMAPPED_READ);
    chk(pse === PAGE_SIZE_EXT_CAP, "size ext");
    avs(1'b1, ADDR_DIR_BASE, 32'h0000_1ABC, q);
    base = 32'h0000_1000;
    rd(ADDR_DIR_BASE, base);
    $display("test done: registers");
    look(32'h0000_3ABC, 0, 0, 2);
    look(32'h0000_3123, 0, 1, 0);
    look(32'h0000_3FFF, 1, 0, 2);
    look(32'h0000_3000, 1, 1, 0);
    look(32'h0000_4010, 1, 0, 2);
    look(32'h0000_5010, 0, 1, 2);
    look(32'h0040_0777, 0, 0, 1);
    rd(ADDR_INVAL, 32'h0040_0777);
    look(32'h0000_6000, 0, 0, 2);
    rd(ADDR_STATUS, 32'(nfault));
    look(32'h0000_5010, 0, 0, 2);
    look(32'h0000_5020, 0, 1, 0);
    mem.ram[30'h803] = 32'h000A_0007;
    avs(1'b1, ADDR_INVAL, 32'h0000_3000, q);
    look(32'h0000_3456, 0, 0, 2);
    avs(1'b1, ADDR_CONFIG, 32'h0000_0010, q);
    rd(ADDR_CONFIG, 32'h0000_0010);
    look(32'h0000_7000, 0, 0, 2);
    look(32'h0000_8000, 0, 0, 1);
    avs(1'b1, ADDR_DIR_BASE, base, q);
    look(32'h0000_8004, 0, 0, 2);
    for (int p = 0; p < 2; p++)
      for (int k = 9; k < 34; k += 8)
        look({10'h0, 10'(k), 12'($random(seed))}, 0, 0, 1 - p);
    test_done();
  end
endmodule // tb
